// [rtl/cpwm_top.sv]
// 8-bit pulse-width compare module with its counter low byte and an
// Avalon-MM register slave; one clock, synchronous active-low reset.
// Assumes the master holds a request until waitrequest is seen low.
`timescale 1ns/10ps
module cpwm_top
  import cpwm_pkg::*;
#(
  parameter int ADDR_W = 5
)
(
  input  wire logic                REF_CLK_I,
  input  wire logic                RESET_N_I,
  input  wire logic [ADDR_W-1:0]   AVS_ADDRESS_I,
  input  wire logic                AVS_READ_I,
  input  wire logic                AVS_WRITE_I,
  input  wire logic [3:0]          AVS_BYTEENABLE_I,
  input  wire logic [31:0]         AVS_WRITEDATA_I,
  output logic      [31:0]         AVS_READDATA_O,
  output logic                     AVS_WAITREQUEST_O,
  output logic                     MODULE_OUTPUT_PIN_O,
  output logic                     IRQ_O
);
  import cpwm_pkg::*;

  // ****************************************************************
  // Parameter check
  // ****************************************************************
  if (ADDR_W < 5)
  begin : g_bad_addr
    $error("ADDR_W must be at least 5");
  end

  // ****************************************************************
  // Decoding helpers
  // ****************************************************************
  function automatic logic pwm8_active(input cpwm_ctrl_t c);
    pwm8_active = c.run && c.comparator_enable && c.pulse_mode_select &&
                  (c.cycle_length_select == CLS_8BIT);
  endfunction : pwm8_active

  function automatic logic [31:0] ctrl_word(input cpwm_ctrl_t c);
    ctrl_word = '0;
    ctrl_word[CTRL_RUN_BIT]            = c.run;
    ctrl_word[CTRL_CMP_EN]             = c.comparator_enable;
    ctrl_word[CTRL_PWM]                = c.pulse_mode_select;
    ctrl_word[CTRL_MFE]                = c.match_flag_enable;
    ctrl_word[CTRL_CLS_LO+1:CTRL_CLS_LO] = c.cycle_length_select;
  endfunction : ctrl_word

  // ****************************************************************
  // State
  // ****************************************************************
  cpwm_state_t   st_r;
  cpwm_state_t   st_nxt;
  cpwm_bus_req_t req;
  logic [2:0]    idx;
  logic          wr_go;
  logic          rd_go;
  logic          wr_lo;
  logic          wrap;
  logic          match;
  logic          ev_set;
  logic [1:0]    st_set;
  logic [1:0]    st_clr;

  assign req.read       = AVS_READ_I;
  assign req.write      = AVS_WRITE_I;
  assign req.address    = AVS_ADDRESS_I[4:0];
  assign req.byteenable = AVS_BYTEENABLE_I;
  assign req.writedata  = AVS_WRITEDATA_I;
  assign idx            = req.address[4:2];
  assign wr_go          = st_r.ack && req.write;
  assign rd_go          = st_r.ack && req.read;
  assign wr_lo          = wr_go && req.byteenable[0];
  assign wrap           = st_r.ctrl.run &&
                          (st_r.counter_low_byte == CNT_MAX);

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb
  begin
    st_nxt = st_r;
    st_set = '0;
    st_clr = '0;
    match  = 1'b0;
    ev_set = 1'b0;

    // Bus handshake: one wait cycle, then one cycle with waitrequest low
    st_nxt.ack = (req.read || req.write) && !st_r.ack;
    if (st_nxt.ack && req.read)
    begin
      case (idx)
        CTRL_IDX:    st_nxt.rdata = ctrl_word(st_r.ctrl);
        CMP_LOW_IDX: st_nxt.rdata = {24'h0, st_r.compare_low_byte};
        DUTY_HI_IDX: st_nxt.rdata = {24'h0, st_r.duty_reload_high_byte};
        COUNTER_IDX: st_nxt.rdata = {24'h0, st_r.counter_low_byte};
        STATUS_IDX:  st_nxt.rdata = {30'h0, st_r.status};
        MASK_IDX:    st_nxt.rdata = {30'h0, st_r.mask};
        default:     st_nxt.rdata = '0;
      endcase
    end

    // Counter low byte
    if (st_r.ctrl.run)
    begin
      st_nxt.counter_low_byte = st_r.counter_low_byte + CNT_ONE;
    end

    // Overflow: reload and flag
    if (wrap)
    begin
      st_nxt.compare_low_byte = st_r.duty_reload_high_byte;
      st_set[ST_OVF_BIT]      = 1'b1;
    end

    // Register writes win over the hardware reload
    if (wr_lo)
    begin
      case (idx)
        CTRL_IDX:
        begin
          st_nxt.ctrl.run                 = req.writedata[CTRL_RUN_BIT];
          st_nxt.ctrl.comparator_enable   = req.writedata[CTRL_CMP_EN];
          st_nxt.ctrl.pulse_mode_select   = req.writedata[CTRL_PWM];
          st_nxt.ctrl.match_flag_enable   = req.writedata[CTRL_MFE];
          st_nxt.ctrl.cycle_length_select =
            req.writedata[CTRL_CLS_LO+1:CTRL_CLS_LO];
        end
        CMP_LOW_IDX:
        begin
          st_nxt.compare_low_byte       = req.writedata[7:0];
          st_nxt.ctrl.comparator_enable = 1'b0;
        end
        DUTY_HI_IDX:
        begin
          st_nxt.duty_reload_high_byte  = req.writedata[7:0];
          st_nxt.ctrl.comparator_enable = 1'b1;
        end
        MASK_IDX:    st_nxt.mask = req.writedata[1:0];
        default:     st_nxt.mask = st_r.mask;
      endcase
    end

    // Output: match sets, overflow clears, match wins for 100 percent
    match = pwm8_active(st_nxt.ctrl) &&
            (st_nxt.counter_low_byte == st_nxt.compare_low_byte);
    if (!pwm8_active(st_nxt.ctrl))
    begin
      st_nxt.module_output_pin = 1'b0;
    end
    else if (match)
    begin
      st_nxt.module_output_pin = 1'b1;
      ev_set = !st_r.module_output_pin;
    end
    else if (wrap)
    begin
      st_nxt.module_output_pin = 1'b0;
    end

    st_set[ST_EVENT_BIT] = ev_set && st_nxt.ctrl.match_flag_enable;

    // Status: read clears only reported bits, a new set wins
    if (rd_go && (idx == STATUS_IDX))
    begin
      st_clr = st_r.rdata[1:0];
    end
    st_nxt.status = (st_r.status & ~st_clr) | st_set;
    st_nxt.irq    = |(st_nxt.status & st_nxt.mask);
  end

  always_ff @(posedge REF_CLK_I)
  begin
    if (!RESET_N_I)
    begin
      st_r <= STATE_RESET;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign AVS_READDATA_O      = st_r.rdata;
  assign AVS_WAITREQUEST_O   = !st_r.ack;
  assign MODULE_OUTPUT_PIN_O = st_r.module_output_pin;
  assign IRQ_O               = st_r.irq;

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge REF_CLK_I);
  endclocking
  default disable iff (!RESET_N_I);

  logic       act_q;
  logic       out_q;
  logic       cen_q;
  logic       mfe_q;
  logic [7:0] cnt_q;
  logic [7:0] cmp_q;
  logic [7:0] dhi_q;
  logic       run_q;
  logic       ovf_q;
  logic       evt_q;
  assign act_q  = pwm8_active(st_r.ctrl);
  assign out_q  = st_r.module_output_pin;
  assign cen_q  = st_r.ctrl.comparator_enable;
  assign mfe_q  = st_r.ctrl.match_flag_enable;
  assign cnt_q  = st_r.counter_low_byte;
  assign cmp_q  = st_r.compare_low_byte;
  assign dhi_q  = st_r.duty_reload_high_byte;
  assign run_q  = st_r.ctrl.run;
  assign ovf_q  = st_r.status[ST_OVF_BIT];
  assign evt_q  = st_r.status[ST_EVENT_BIT];

  sequence s_wrap;
    wrap && !(wr_lo && (idx == CMP_LOW_IDX));
  endsequence

  sequence s_wr_low;
    wr_lo && (idx == CMP_LOW_IDX);
  endsequence

  sequence s_wr_high;
    wr_lo && (idx == DUTY_HI_IDX);
  endsequence

  chk_match_drives_high: assert property (
    act_q && (cnt_q == cmp_q) |-> out_q)
    else $error("output low on compare match");

  chk_overflow_drives_low: assert property (
    wrap && act_q && $past(act_q) && (dhi_q != BYTE_ZERO) && !wr_lo
      |=> !out_q)
    else $error("output high after overflow");

  chk_reload_on_wrap: assert property (
    s_wrap |=> (cmp_q == $past(dhi_q)))
    else $error("compare low not reloaded at rollover");

  chk_out_needs_mode: assert property (
    out_q |-> act_q)
    else $error("output high outside 8-bit mode");

  chk_event_flag_set: assert property (
    $rose(out_q) && mfe_q |-> evt_q)
    else $error("event flag missing on rising edge");

  chk_overflow_flag: assert property (
    wrap |=> ovf_q)
    else $error("overflow flag missing");

  chk_low_write_clears: assert property (
    s_wr_low |=> !cen_q ##1 (!cen_q || $past(wr_lo)))
    else $error("compare low write left enable set");

  chk_high_write_sets: assert property (
    s_wr_high |=> cen_q)
    else $error("compare high write left enable clear");

  chk_full_duty: assert property (
    act_q && (dhi_q == BYTE_ZERO) && (cmp_q == BYTE_ZERO) && wrap &&
      !wr_lo |=> out_q)
    else $error("zero high byte not full duty");

  chk_disabled_low: assert property (
    !cen_q |-> !out_q)
    else $error("output high with comparator disabled");

  chk_count_step: assert property (
    run_q |=> (cnt_q == $past(cnt_q) + CNT_ONE))
    else $error("counter did not step");

  chk_count_hold: assert property (
    !run_q |=> $stable(cnt_q))
    else $error("counter moved while stopped");

  chk_event_needs_enable: assert property (
    $rose(evt_q) |-> mfe_q)
    else $error("event flag set with match flag disabled");

  chk_overflow_only_wrap: assert property (
    $rose(ovf_q) |-> $past(wrap))
    else $error("overflow flag set without rollover");

  chk_irq_level: assert property (
    |(st_r.status & st_r.mask) |-> IRQ_O)
    else $error("interrupt low with unmasked status");

  chk_wait_release: assert property (
    (AVS_READ_I || AVS_WRITE_I) && AVS_WAITREQUEST_O |=> !AVS_WAITREQUEST_O)
    else $error("waitrequest not released");

endmodule : cpwm_top

// [common/cpwm_pkg.sv]
// Constants and state layout of the 8-bit pulse-width compare module.
// Assumes an Avalon-MM master with a 32-bit data path and byte addresses.
package cpwm_pkg;

  // ****************************************************************
  // Register map and fields
  // ****************************************************************
  localparam logic [2:0] CTRL_IDX     = 3'h0;
  localparam logic [2:0] CMP_LOW_IDX  = 3'h1;
  localparam logic [2:0] DUTY_HI_IDX  = 3'h2;
  localparam logic [2:0] COUNTER_IDX  = 3'h3;
  localparam logic [2:0] STATUS_IDX   = 3'h4;
  localparam logic [2:0] MASK_IDX     = 3'h5;

  localparam int         CTRL_RUN_BIT = 0;
  localparam int         CTRL_CMP_EN  = 1;
  localparam int         CTRL_PWM     = 2;
  localparam int         CTRL_MFE     = 3;
  localparam int         CTRL_CLS_LO  = 4;
  localparam int         ST_EVENT_BIT = 0;
  localparam int         ST_OVF_BIT   = 1;

  localparam logic [1:0] CLS_8BIT     = 2'h0;
  localparam logic [7:0] CNT_MAX      = 8'hff;
  localparam logic [7:0] CNT_ONE      = 8'h01;
  localparam logic [7:0] BYTE_ZERO    = 8'h00;
  localparam int         PERIOD_CNT   = 256;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef struct packed {
    logic       run;
    logic       comparator_enable;
    logic       pulse_mode_select;
    logic       match_flag_enable;
    logic [1:0] cycle_length_select;
  } cpwm_ctrl_t;

  typedef struct packed {
    logic        read;
    logic        write;
    logic [4:0]  address;
    logic [3:0]  byteenable;
    logic [31:0] writedata;
  } cpwm_bus_req_t;

  typedef struct packed {
    cpwm_ctrl_t  ctrl;
    logic [7:0]  counter_low_byte;
    logic [7:0]  compare_low_byte;
    logic [7:0]  duty_reload_high_byte;
    logic        module_output_pin;
    logic [1:0]  status;
    logic [1:0]  mask;
    logic        irq;
    logic        ack;
    logic [31:0] rdata;
  } cpwm_state_t;

  localparam cpwm_state_t STATE_RESET = '0;

endpackage : cpwm_pkg

// [tb/cpwm_load_model.sv]
// Load on the pulse output: measures high time and period.
// Assumes one clock shared with the pulse generator.
`timescale 1ns/10ps
module cpwm_load_model
(
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        pin_i,
  output logic      [8:0]  last_high_o,
  output logic      [9:0]  last_period_o,
  output logic      [15:0] fall_count_o
);
  logic       pin_d;
  logic [8:0] hi;
  logic [9:0] per;

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      {pin_d, hi, per, last_high_o, last_period_o, fall_count_o} <= '0;
    end
    else
    begin
      pin_d <= pin_i;
      if (pin_d && !pin_i)
      begin
        last_high_o   <= hi;
        last_period_o <= per;
        fall_count_o  <= fall_count_o + 16'h0001;
        hi            <= 9'h000;
        per           <= 10'h001;
      end
      else
      begin
        hi  <= hi + {8'h00, pin_i};
        per <= per + 10'h001;
      end
    end
  end
endmodule : cpwm_load_model

// [tb/tb_counter_array_8bit_pwm_module.sv]
// Bench for the pulse compare module over its register bus.
// Assumes the package constants for register indexes.
`timescale 1ns/10ps
module tb_counter_array_8bit_pwm_module;
  import cpwm_pkg::*;
  logic        clk = 0;
  logic        rst_n = 0;
  logic [4:0]  adr = '0;
  logic        rd_en = 0;
  logic        wr_en = 0;
  logic [3:0]  be = '0;
  logic [31:0] wdat = '0;
  logic [31:0] rdat;
  logic        waitreq;
  logic        pin;
  logic        irq;
  logic [8:0]  high_t;
  logic [9:0]  period_t;
  logic [15:0] falls;
  logic [31:0] q;
  int          bad_count = 0;
  int          samples_checked = 0;
  int          cycles = 0;
  logic [7:0]  duty [3] = '{8'h01, 8'hff, 8'h80};
  logic [7:0]  offc [3] = '{8'h17, 8'h03, 8'h06};

  cpwm_top dut (.REF_CLK_I(clk), .RESET_N_I(rst_n), .AVS_ADDRESS_I(adr),
    .AVS_READ_I(rd_en), .AVS_WRITE_I(wr_en), .AVS_BYTEENABLE_I(be),
    .AVS_WRITEDATA_I(wdat), .AVS_READDATA_O(rdat),
    .AVS_WAITREQUEST_O(waitreq), .MODULE_OUTPUT_PIN_O(pin), .IRQ_O(irq));
  cpwm_load_model load (.clk_i(clk), .rst_n_i(rst_n), .pin_i(pin),
    .last_high_o(high_t), .last_period_o(period_t), .fall_count_o(falls));

  always #5 clk = ~clk;

  // ****************************************************************
  // Tasks
  // ****************************************************************
  task final_report;
  begin
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  end
  endtask : final_report

  task check_eq(input logic [31:0] seen, input logic [31:0] exp);
  begin
    samples_checked++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  end
  endtask : check_eq

  task xfer(input logic w, input logic [2:0] i, input logic [3:0] b,
            input logic [31:0] d);
  begin
    @(posedge clk);
    adr   <= {i, 2'b00};
    wr_en <= w;
    rd_en <= !w;
    be    <= b;
    wdat  <= d;
    do
    begin
      @(posedge clk);
    end
    while (waitreq !== 1'b0);
    q = rdat;
    wr_en <= 1'b0;
    rd_en <= 1'b0;
  end
  endtask : xfer

  task wr(input logic [2:0] i, input logic [7:0] d);
  begin
    xfer(1'b1, i, 4'h1, {24'h0, d});
  end
  endtask : wr

  task rd(input logic [2:0] i);
  begin
    xfer(1'b0, i, 4'hf, 32'h0);
  end
  endtask : rd

  task wait_falls(input int k);
    logic [15:0] tgt;
  begin
    tgt = falls + k[15:0];
    while (falls != tgt)
    begin
      @(posedge clk);
    end
  end
  endtask : wait_falls

  task high_cnt(input int exp);
    int h;
    int l;
  begin
    h = 0;
    l = 0;
    repeat (400) @(posedge clk);
    repeat (256)
    begin
      @(posedge clk);
      h += (pin === 1'b1);
      l += (pin === 1'b0);
    end
    check_eq(h, exp);
    check_eq(l, 256 - exp);
  end
  endtask : high_cnt

  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      bad_count++;
      final_report();
    end
  end

  // ****************************************************************
  // Tests
  // ****************************************************************
  initial
  begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 8; i++)
    begin
      rd(i[2:0]);
      check_eq(q, 32'h0);
    end
    check_eq({pin, irq}, 32'h0);
    wr(COUNTER_IDX, 8'h55);
    rd(COUNTER_IDX);
    check_eq(q, 32'h0);
    xfer(1'b1, CTRL_IDX, 4'h0, 32'h0f);
    wr(3'h6, 8'hff);
    rd(3'h6);
    check_eq(q, 32'h0);
    rd(CTRL_IDX);
    check_eq(q, 32'h0);
    wr(CTRL_IDX, 8'h0f);
    wr(CMP_LOW_IDX, 8'h40);
    rd(CTRL_IDX);
    check_eq(q, 32'h0d);
    wr(DUTY_HI_IDX, 8'hc0);
    rd(CTRL_IDX);
    check_eq(q, 32'h0f);
    wait_falls(2);
    check_eq(high_t, 32'd64);
    check_eq(period_t, PERIOD_CNT);
    repeat (2) @(posedge clk);
    check_eq(irq, 32'h0);
    wr(MASK_IDX, 8'h02);
    repeat (2) @(posedge clk);
    check_eq(irq, 32'h1);
    rd(STATUS_IDX);
    check_eq(q, 32'h3);
    repeat (2) @(posedge clk);
    check_eq(irq, 32'h0);
    wr(CTRL_IDX, 8'h07);
    wait_falls(2);
    rd(STATUS_IDX);
    check_eq(q, 32'h2);
    foreach (duty[i])
    begin
      wr(DUTY_HI_IDX, duty[i]);
      wait_falls(2);
      check_eq(high_t, 32'd256 - duty[i]);
      check_eq(period_t, PERIOD_CNT);
    end
    wr(DUTY_HI_IDX, 8'h00);
    high_cnt(256);
    wr(CMP_LOW_IDX, 8'h10);
    high_cnt(0);
    wr(DUTY_HI_IDX, 8'h80);
    foreach (offc[i])
    begin
      wr(CTRL_IDX, offc[i]);
      high_cnt(0);
    end
    wr(CTRL_IDX, 8'h07);
    high_cnt(128);
    final_report();
  end
endmodule : tb_counter_array_8bit_pwm_module
